// ---- hw/ccir_pkg.sv ----
package ccir_pkg;
  localparam logic [7:0] CCIR_OFS_CHARGER_CONTROL_TWO = 8'h02;
  localparam logic [7:0] CCIR_OFS_STAT = 8'h03;
  localparam logic [7:0] CCIR_OFS_CH1 = 8'h04;
  localparam logic [7:0] CCIR_OFS_CH2 = 8'h05;
  localparam logic [7:0] CCIR_OFS_BST = 8'h06;
  localparam logic [7:0] CCIR_OFS_SNS = 8'h07;
  localparam logic [7:0] CCIR_CHARGER_CONTROL_TWO_RST = 8'h16;
  localparam int CCIR_BIT_WDOG_OFF = 7;
  localparam int CCIR_BIT_CHG_TMR_OFF = 6;
  localparam int CCIR_BIT_POWER_PATH_ON = 5;
  localparam int CCIR_BIT_XCVR = 4;
  localparam int CCIR_BIT_FACTORY = 3;
  localparam int CCIR_BIT_LIM_PINS = 2;
  localparam int CCIR_BIT_LIM_ON = 1;
  localparam int CCIR_BIT_AUTO_CUR = 0;
  localparam int CCIR_WDOG_S = 32;
  localparam int CCIR_USB_S = 2048;
  localparam int CCIR_CHG_S = 3600;
endpackage : ccir_pkg

// ---- hw/ccir_flag_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface ccir_flag_if #(parameter int W = 8);
  logic [W-1:0] cond;
  logic [W-1:0] single_mask;
  logic rd;
  logic clr;
  logic [W-1:0] flags;
  modport bank (input cond, single_mask, rd, clr, output flags);
  modport user (output cond, single_mask, rd, clr, input flags);
endinterface : ccir_flag_if
`default_nettype wire

// ---- hw/ccir_flag_bank.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccir_flag_bank
  import ccir_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Flag group
  ccir_flag_if.bank fi
);
  logic [W-1:0] flags_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_flag
      // Set wins over clear; every flag stays while its condition holds (single_mask is not used)
      always_ff @(posedge clk_sys) begin
        if (rst || fi.clr) begin
          flags_q[i] <= fi.cond[i] && !rst;
        end else if (fi.cond[i]) begin
          flags_q[i] <= 1'b1;
        end else if (fi.rd) begin
          flags_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign fi.flags = flags_q;
endmodule : ccir_flag_bank
`default_nettype wire

// ---- hw/ccir_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccir_regs
  import ccir_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Comparator inputs (analogue, asynchronous)
  input wire logic [5:0] die_temp_in,
  input wire logic input_lockout_in,
  input wire logic extended_range_in,
  input wire logic usb_over_in,
  input wire logic usb_under_in,
  input wire logic input_detect_in,
  input wire logic detect_margin_in,
  input wire logic boost_uv_in,
  input wire logic battery_removed_in,
  input wire logic battery_over_in,
  input wire logic [3:0] battery_temp_in,
  input wire logic [2:0] boost_fault_in,
  // Timer expiry and timer reset events (same clock)
  input wire logic watchdog_expired,
  input wire logic usb_timer_expired,
  input wire logic charge_timer_expired,
  input wire logic timer_reset,
  // Control outputs
  output logic watchdog_off,
  output logic charge_timer_off,
  output logic power_path_on,
  output logic xcvr_supply_on,
  output logic factory_mode_on,
  output logic limit_from_pins,
  output logic input_limit_on,
  output logic auto_current_on
);
  localparam int NS = 20;

  logic [7:0] charger_control_two_q;
  logic [NS-1:0] s1_q, s2_q, s3_q, live_q;
  logic [NS-1:0] raw;
  logic [7:0] rdata_q;
  logic rd_stat, rd_ch1, rd_ch2, rd_bst;

  // Raw asynchronous comparator bundle
  assign raw = {boost_fault_in, battery_temp_in, battery_over_in, battery_removed_in,
                boost_uv_in, detect_margin_in, input_detect_in, usb_under_in,
                usb_over_in, extended_range_in, input_lockout_in, die_temp_in[3:0]};

  // Three stages; live value moves only when stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      live_q <= '0;
    end else begin
      live_q <= (s2_q & s3_q) | (live_q & (s2_q | s3_q));
    end
  end

  // Control register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      charger_control_two_q <= CCIR_CHARGER_CONTROL_TWO_RST;
    end else if (reg_wr && reg_addr == CCIR_OFS_CHARGER_CONTROL_TWO) begin
      charger_control_two_q <= reg_wdata;
    end
  end

  assign watchdog_off = charger_control_two_q[CCIR_BIT_WDOG_OFF];
  assign charge_timer_off = charger_control_two_q[CCIR_BIT_CHG_TMR_OFF];
  assign power_path_on = charger_control_two_q[CCIR_BIT_POWER_PATH_ON];
  assign xcvr_supply_on = charger_control_two_q[CCIR_BIT_XCVR];
  assign factory_mode_on = charger_control_two_q[CCIR_BIT_FACTORY];
  assign limit_from_pins = charger_control_two_q[CCIR_BIT_LIM_PINS];
  assign input_limit_on = charger_control_two_q[CCIR_BIT_LIM_ON];
  assign auto_current_on = charger_control_two_q[CCIR_BIT_AUTO_CUR];

  assign rd_stat = reg_rd && reg_addr == CCIR_OFS_STAT;
  assign rd_ch1 = reg_rd && reg_addr == CCIR_OFS_CH1;
  assign rd_ch2 = reg_rd && reg_addr == CCIR_OFS_CH2;
  assign rd_bst = reg_rd && reg_addr == CCIR_OFS_BST;

  // Status flags: bits 5..0
  ccir_flag_if #(.W(6)) stat_if ();
  logic usb_range;
  assign usb_range = !live_q[6] && !live_q[7];
  assign stat_if.cond = {live_q[3:0], live_q[5], usb_range};
  assign stat_if.single_mask = '0;
  assign stat_if.rd = rd_stat;
  assign stat_if.clr = 1'b0;
  ccir_flag_bank #(.W(6)) u_stat (.clk_sys(clk_sys), .rst(rst), .fi(stat_if));

  // First charger flags: bits 4..1
  ccir_flag_if #(.W(4)) ch1_if ();
  logic chg_detect;
  assign chg_detect = live_q[9] && !live_q[8];
  assign ch1_if.cond = {chg_detect, live_q[4], live_q[11], live_q[12]};
  assign ch1_if.single_mask = '0;
  assign ch1_if.rd = rd_ch1;
  assign ch1_if.clr = 1'b0;
  ccir_flag_bank #(.W(4)) u_ch1 (.clk_sys(clk_sys), .rst(rst), .fi(ch1_if));

  // Second charger flags, battery temperature: bits 7..4
  ccir_flag_if #(.W(4)) ch2_if ();
  assign ch2_if.cond = live_q[16:13];
  assign ch2_if.single_mask = '0;
  assign ch2_if.rd = rd_ch2;
  assign ch2_if.clr = 1'b0;
  ccir_flag_bank #(.W(4)) u_ch2 (.clk_sys(clk_sys), .rst(rst), .fi(ch2_if));

  // Timer expiry flags clear on a read of the second charger register or on timer_reset
  logic [2:0] tmr_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tmr_q <= '0;
    end else begin
      tmr_q[2] <= watchdog_expired || (tmr_q[2] && !rd_ch2 && !timer_reset);
      tmr_q[1] <= usb_timer_expired || (tmr_q[1] && !rd_ch2 && !timer_reset);
      tmr_q[0] <= charge_timer_expired || (tmr_q[0] && !rd_ch2 && !timer_reset);
    end
  end

  // Boost flags: bits 2..0
  ccir_flag_if #(.W(3)) bst_if ();
  assign bst_if.cond = live_q[19:17];
  assign bst_if.single_mask = '0;
  assign bst_if.rd = rd_bst;
  assign bst_if.clr = 1'b0;
  ccir_flag_bank #(.W(3)) u_bst (.clk_sys(clk_sys), .rst(rst), .fi(bst_if));

  logic summary_from_first, summary_from_second;
  assign summary_from_first = |ch1_if.flags;
  assign summary_from_second = |{ch2_if.flags, tmr_q};

  // Registered read data, one cycle after the read strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        CCIR_OFS_CHARGER_CONTROL_TWO: rdata_q <= charger_control_two_q;
        CCIR_OFS_STAT: rdata_q <= {2'b00, stat_if.flags};
        CCIR_OFS_CH1: rdata_q <= {3'b000, ch1_if.flags, summary_from_second};
        CCIR_OFS_CH2: rdata_q <= {ch2_if.flags, tmr_q, summary_from_first};
        CCIR_OFS_BST: rdata_q <= {5'b00000, bst_if.flags};
        CCIR_OFS_SNS: rdata_q <= {live_q[4], live_q[5], live_q[6], live_q[7],
                                  live_q[8], live_q[9], live_q[10], 1'b0};
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign reg_rdata = rdata_q;
endmodule : ccir_regs
`default_nettype wire

// ---- verif/ccir_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccir_host (
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Flags are acknowledged by reading them back; timer expiry flags also by timer_reset
  task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // Released bus shows a changed value, not the stale one
    reg_addr = ~a;
    reg_wdata = ~d;
    q = reg_rdata;
  endtask : access
endmodule : ccir_host
`default_nettype wire

// ---- verif/ccir_regs_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccir_regs_asserts
  import ccir_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port and timer events
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic watchdog_expired,
  input wire logic timer_reset,
  // Control outputs
  input wire logic watchdog_off,
  input wire logic charge_timer_off,
  input wire logic power_path_on,
  input wire logic xcvr_supply_on,
  input wire logic factory_mode_on,
  input wire logic limit_from_pins,
  input wire logic input_limit_on,
  input wire logic auto_current_on
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire [7:0] c = {watchdog_off, charge_timer_off, power_path_on, xcvr_supply_on,
    factory_mode_on, limit_from_pins, input_limit_on, auto_current_on};
  wire w2 = reg_wr && reg_addr == CCIR_OFS_CHARGER_CONTROL_TWO;
  property p_rst; $fell(rst) |-> c == CCIR_CHARGER_CONTROL_TWO_RST; endproperty
  a_rst: assert property (p_rst) else $error("ctrl reset value");
  property p_wr; w2 |=> c == $past(reg_wdata); endproperty
  a_wr: assert property (p_wr) else $error("ctrl write");
  property p_hold; !w2 |=> $stable(c); endproperty
  a_hold: assert property (p_hold) else $error("ctrl changed");
  property p_rd2; reg_rd && reg_addr == CCIR_OFS_CHARGER_CONTROL_TWO |=> reg_rdata == $past(c); endproperty
  a_rd2: assert property (p_rd2) else $error("ctrl readback");
  property p_stat; reg_rd && reg_addr == CCIR_OFS_STAT |=> reg_rdata[7:6] == 2'b00; endproperty
  a_stat: assert property (p_stat) else $error("stat reserved");
  property p_bst; reg_rd && reg_addr == CCIR_OFS_BST |=> reg_rdata[7:3] == 5'h00; endproperty
  a_bst: assert property (p_bst) else $error("boost reserved");
  property p_sns; reg_rd && reg_addr == CCIR_OFS_SNS |=> !reg_rdata[0]; endproperty
  a_sns: assert property (p_sns) else $error("sense bit0");
  property p_wdog;
    watchdog_expired ##1 (reg_rd && reg_addr == CCIR_OFS_CH2 && !timer_reset) |=> reg_rdata[3];
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog flag");
endmodule : ccir_regs_asserts
bind ccir_regs ccir_regs_asserts u_chk (.*);
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ccir_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
  logic reg_wr, reg_rd;
  logic timer_reset = 1'b0;
  logic [2:0] tmr = 3'b000;
  logic [19:0] pin = '0;
  logic watchdog_off, charge_timer_off, power_path_on, xcvr_supply_on;
  logic factory_mode_on, limit_from_pins, input_limit_on, auto_current_on;
  wire [7:0] ctl = {watchdog_off, charge_timer_off, power_path_on, xcvr_supply_on,
    factory_mode_on, limit_from_pins, input_limit_on, auto_current_on};
  int n_mismatch = 0, n_checks = 0, m_ctrl, x = 69;
  int ta[16] = '{3, 3, 3, 3, 3, 4, 4, 4, 4, 5, 5, 5, 5, 6, 6, 6};
  int tbit[16] = '{2, 3, 4, 5, 1, 3, 4, 2, 1, 4, 5, 6, 7, 0, 1, 2};
  ccir_host host (.*);
  ccir_regs dut (.*, .die_temp_in({2'b00, pin[3:0]}), .extended_range_in(pin[4]),
    .input_lockout_in(pin[5]), .detect_margin_in(pin[6]), .battery_removed_in(pin[7]),
    .battery_over_in(pin[8]), .battery_temp_in(pin[12:9]), .boost_fault_in(pin[15:13]),
    .usb_over_in(pin[16]), .usb_under_in(pin[17]), .input_detect_in(pin[18]),
    .boost_uv_in(pin[19]), .watchdog_expired(tmr[2]), .usb_timer_expired(tmr[1]),
    .charge_timer_expired(tmr[0]));
  initial forever #10 clk_sys = ~clk_sys;
  function automatic int xs();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    host.access(a, 1'b0, 8'h00, q);
    chk(nm, e, q);
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wt
  task automatic summarize();
    if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
  initial begin
    wt(20);
    rst = 1'b0;
    wt(8);
    rd(CCIR_OFS_CHARGER_CONTROL_TWO, CCIR_CHARGER_CONTROL_TWO_RST, "ctrl reset");
    repeat (4) begin
      m_ctrl = xs() & 255;
      host.access(CCIR_OFS_CHARGER_CONTROL_TWO, 1'b1, m_ctrl[7:0], q);
      host.access(CCIR_OFS_STAT, 1'b1, ~m_ctrl[7:0], q);
      rd(CCIR_OFS_CHARGER_CONTROL_TWO, m_ctrl[7:0], "ctrl read");
      chk("ctrl pins", m_ctrl[7:0], ctl);
      rd(CCIR_OFS_STAT, 8'h01, "usb range");
    end
    foreach (ta[i]) begin
      pin = 20'h1 << i;
      wt(8);
      if (ta[i] inside {4, 5}) rd(8'(9 - ta[i]), 8'h01, "summary");
      rd(8'(ta[i]), 8'(ta[i] == 3) | 8'(1 << tbit[i]), "flag held");
      pin = '0;
      wt(8);
      rd(8'(ta[i]), 8'(ta[i] == 3) | 8'(1 << tbit[i]), "flag latched");
      rd(8'(ta[i]), 8'(ta[i] == 3), "flag gone");
    end
    for (int k = 0; k < 3; k++) begin
      tmr = 3'(1 << k);
      fork
        rd(CCIR_OFS_CH2, 8'(2 << k), "timer set");
        begin
          wt(1);
          tmr = 3'b000;
        end
      join
      rd(CCIR_OFS_CH2, 8'h00, "timer read clear");
    end
    tmr = 3'b100;
    wt(1);
    tmr = 3'b000;
    rd(CCIR_OFS_CH1, 8'h01, "timer summary");
    timer_reset = 1'b1;
    wt(1);
    timer_reset = 1'b0;
    rd(CCIR_OFS_CH2, 8'h00, "timer reset");
    repeat (6) begin
      pin = 20'(xs());
      wt(8);
      rd(CCIR_OFS_SNS, {pin[5:4], pin[16], pin[17], pin[18], pin[6], pin[19], 1'b0},
        "sense");
    end
    rd(8'h08, 8'h00, "unmapped");
    summarize();
  end
endmodule : tb
`default_nettype wire
